// ---- shared/pin_mux_consts.vh ----
// constants for the port pin function multiplexer
`ifndef PIN_MUX_CONSTS_VH
`define PIN_MUX_CONSTS_VH
// ==========================================
// reset values
`define PORT_DIR_RESET 8'h00
`define PORT_SEL_RESET 8'h00
`define PIN_OFF_RESET 8'h00
`define CA_SEL_RESET 5'h00
// ==========================================
// register offsets on the plain port
`define REG_P1_DIR 3'h0
`define REG_P1_SEL 3'h1
`define REG_P2_DIR 3'h2
`define REG_P2_SEL 3'h3
`define REG_PIN_OFF 3'h4
`define REG_CA_SEL 3'h5
`define REG_STATUS 3'h6
`define REG_P1_IN 3'h7
// ==========================================
// comparator select field positions
`define CA_BIT0 0
`define CA_BIT1 1
`define CA_BIT2 2
`define CA_BIT3 3
`define CA_BIT4 4
`endif

// ---- verilog/pin_sync.v ----
// three-flop synchroniser bank for pad inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 8
) (
	input wire i_clk,
	input wire i_reset,
	input wire [WIDTH-1:0] i_async,
	output reg [WIDTH-1:0] o_sync
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;
	genvar g;
	always @(posedge i_clk) begin
		if (i_reset) begin
			stage1 <= {WIDTH{1'b0}};
			stage2 <= {WIDTH{1'b0}};
			stage3 <= {WIDTH{1'b0}};
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end
	// change accepted only when second and third agree
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			always @(posedge i_clk) begin
				if (i_reset)
					o_sync[g] <= 1'b0;
				else if (stage2[g] == stage3[g])
					o_sync[g] <= stage3[g];
			end
		end
	endgenerate
endmodule // pin_sync

// ---- verilog/port_pin_function_mux.v ----
// pin function multiplexer for two 8-bit ports
// Function
// - reset puts every pin in general I/O
// - function from direction, select, test, analog
// - select clear: general I/O, direction sets driver
// - pin-disable kills driver and Schmitt input
// - comparator-routed pin loses digital input buffer
// - pair bits route analog inputs 0 to 2
// - three-bit code routes analog inputs 1 to 7
// - test mode hands upper port-1 pins to JTAG while the fuse is intact
// - JTAG decides shared data pin roles
// - blown fuse forces JTAG bypass forever
`timescale 1ns/1ps
`include "pin_mux_consts.vh"
module port_pin_function_mux (
	input wire i_clk,
	input wire i_reset,
	input wire [2:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_write,
	input wire i_read,
	output reg [7:0] o_rdata,
	input wire [7:0] i_port1_pad,
	output reg [7:0] o_port1_out,
	output reg [7:0] o_port1_oe,
	input wire [7:0] i_port2_pad,
	output reg [7:0] o_port2_out,
	output reg [7:0] o_port2_oe,
	output reg [7:0] o_port2_schmitt_en,
	output reg [7:0] o_port2_analog_sel,
	input wire [7:0] i_port1_gpio_out,
	input wire [7:0] i_port2_gpio_out,
	output reg [7:0] o_port1_gpio_in,
	output reg [7:0] o_port2_gpio_in,
	output reg o_timer_external_clock_in,
	output reg o_timer_alternate_clock_in,
	output reg o_timer_capture0_input_a,
	output reg o_timer_capture0_input_b,
	input wire i_timer_channel0_output,
	input wire i_timer_channel1_output,
	input wire i_timer_channel2_output,
	input wire i_sub_main_clock_output,
	input wire i_aux_clock_output,
	input wire i_comparator_result_output,
	input wire i_test_mode,
	input wire i_fuse_blown,
	input wire i_jtag_pin6_drive,
	input wire i_jtag_pin7_drive,
	input wire i_jtag_tdo,
	output reg o_jtag_tck,
	output reg o_jtag_tms,
	output reg o_jtag_tdi_test_clock_input,
	output reg o_jtag_pin7_in,
	output reg o_jtag_enable,
	output reg o_jtag_bypass
);
	// ==========================================
	// control registers
	reg [7:0] port1_direction_bits;
	reg [7:0] port1_function_select_bits;
	reg [7:0] port2_direction_bits;
	reg [7:0] port2_function_select_bits;
	reg [7:0] comparator_pin_disable_bits;
	reg [4:0] comparator_select;
	// power-on clear; nothing but a blown fuse ever changes it
	reg fuse_latched = 1'b0;
	wire [7:0] p1_in;
	wire [7:0] p2_in;
	wire test_sync;
	wire fuse_sync;
	wire comparator_pair_select_bit0 = comparator_select[`CA_BIT0];
	wire comparator_code_select_bit1 = comparator_select[`CA_BIT1];
	wire comparator_code_select_bit2 = comparator_select[`CA_BIT2];
	wire comparator_code_select_bit3 = comparator_select[`CA_BIT3];
	wire comparator_pair_select_bit4 = comparator_select[`CA_BIT4];
	wire [1:0] pair_code = {comparator_pair_select_bit4,
		comparator_pair_select_bit0};
	wire [2:0] tri_code = {comparator_code_select_bit3,
		comparator_code_select_bit2, comparator_code_select_bit1};

	pin_sync #(.WIDTH(8)) u_sync_p1 (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async(i_port1_pad),
		.o_sync(p1_in)
	);
	pin_sync #(.WIDTH(8)) u_sync_p2 (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async(i_port2_pad),
		.o_sync(p2_in)
	);
	pin_sync #(.WIDTH(2)) u_sync_ctl (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_async({i_fuse_blown, i_test_mode}),
		.o_sync({fuse_sync, test_sync})
	);

	// ==========================================
	// register writes
	always @(posedge i_clk) begin
		if (i_reset) begin
			port1_direction_bits <= `PORT_DIR_RESET;
			port1_function_select_bits <= `PORT_SEL_RESET;
			port2_direction_bits <= `PORT_DIR_RESET;
			port2_function_select_bits <= `PORT_SEL_RESET;
			comparator_pin_disable_bits <= `PIN_OFF_RESET;
			comparator_select <= `CA_SEL_RESET;
		end else if (i_write) begin
			case (i_addr)
			`REG_P1_DIR: port1_direction_bits <= i_wdata;
			`REG_P1_SEL: port1_function_select_bits <= i_wdata;
			`REG_P2_DIR: port2_direction_bits <= i_wdata;
			`REG_P2_SEL: port2_function_select_bits <= i_wdata;
			`REG_PIN_OFF: comparator_pin_disable_bits <= i_wdata;
			`REG_CA_SEL: comparator_select <= i_wdata[4:0];
			default: ;
			endcase
		end
	end

	// fuse is sticky: reset cannot undo it
	always @(posedge i_clk) begin
		if (fuse_sync)
			fuse_latched <= 1'b1;
	end

	// ==========================================
	// analog routing decode
	function [7:0] analog_route;
		input [1:0] pc;
		input [2:0] tc;
		reg [7:0] a;
		begin
			a = 8'h00;
			// analog input n routes: pin map 0->p2.3 1->p2.4 2->p2.0
			a[3] = (pc == 2'b01);
			a[4] = (pc == 2'b10) | (tc == 3'b001);
			a[0] = (pc == 2'b11) | (tc == 3'b010);
			a[1] = (tc == 3'b011);
			a[2] = (tc == 3'b100);
			a[5] = (tc == 3'b101);
			a[6] = (tc == 3'b110);
			a[7] = (tc == 3'b111);
			analog_route = a;
		end
	endfunction

	// ==========================================
	// pin function decode
	reg [7:0] next_p1_out;
	reg [7:0] next_p1_oe;
	reg [7:0] next_p2_out;
	reg [7:0] next_p2_oe;
	reg [7:0] next_p2_schmitt;
	reg [7:0] next_analog;
	reg [7:0] p2_periph_out;
	reg [7:0] p1_periph_out;
	reg jtag_on;
	integer k;
	always @* begin
		jtag_on = test_sync & ~fuse_latched;
		next_analog = analog_route(pair_code, tri_code);
		// input-only peripherals drive ground when output selected
		p1_periph_out = {i_timer_channel2_output, i_timer_channel1_output,
			i_timer_channel0_output, i_sub_main_clock_output,
			i_timer_channel2_output, i_timer_channel1_output,
			i_timer_channel0_output, 1'b0};
		p2_periph_out = {2'b00, 1'b0, i_timer_channel2_output,
			i_timer_channel1_output, i_comparator_result_output, 1'b0,
			i_aux_clock_output};
		for (k = 0; k < 8; k = k + 1) begin
			next_p1_oe[k] = port1_direction_bits[k];
			next_p1_out[k] = port1_function_select_bits[k] ?
				p1_periph_out[k] : i_port1_gpio_out[k];
			next_p2_oe[k] = port2_direction_bits[k] &
				~comparator_pin_disable_bits[k];
			next_p2_out[k] = port2_function_select_bits[k] ?
				p2_periph_out[k] : i_port2_gpio_out[k];
			next_p2_schmitt[k] = ~comparator_pin_disable_bits[k] &
				~next_analog[k];
		end
		if (jtag_on) begin
			next_p1_oe[4] = 1'b0;
			next_p1_oe[5] = 1'b0;
			next_p1_oe[6] = i_jtag_pin6_drive;
			next_p1_oe[7] = i_jtag_pin7_drive;
			next_p1_out[4] = 1'b0;
			next_p1_out[5] = 1'b0;
			next_p1_out[6] = 1'b0;
			next_p1_out[7] = i_jtag_tdo;
		end
	end

	// ==========================================
	// registered outputs
	always @(posedge i_clk) begin
		if (i_reset) begin
			o_port1_out <= 8'h00;
			o_port1_oe <= 8'h00;
			o_port2_out <= 8'h00;
			o_port2_oe <= 8'h00;
			o_port2_schmitt_en <= 8'hff;
			o_port2_analog_sel <= 8'h00;
			o_port1_gpio_in <= 8'h00;
			o_port2_gpio_in <= 8'h00;
			o_timer_external_clock_in <= 1'b0;
			o_timer_alternate_clock_in <= 1'b0;
			o_timer_capture0_input_a <= 1'b0;
			o_timer_capture0_input_b <= 1'b0;
			o_jtag_tck <= 1'b0;
			o_jtag_tms <= 1'b1;
			o_jtag_tdi_test_clock_input <= 1'b0;
			o_jtag_pin7_in <= 1'b0;
			o_jtag_enable <= 1'b0;
			o_jtag_bypass <= 1'b0;
			o_rdata <= 8'h00;
		end else begin
			o_port1_out <= next_p1_out;
			o_port1_oe <= next_p1_oe;
			o_port2_out <= next_p2_out;
			o_port2_oe <= next_p2_oe;
			o_port2_schmitt_en <= next_p2_schmitt;
			o_port2_analog_sel <= next_analog;
			o_port1_gpio_in <= p1_in;
			// disabled buffer reads low
			o_port2_gpio_in <= p2_in & next_p2_schmitt;
			o_timer_external_clock_in <= p1_in[0] &
				port1_function_select_bits[0] & ~port1_direction_bits[0];
			o_timer_capture0_input_a <= |(p1_in[3:1] &
				port1_function_select_bits[3:1] &
				~port1_direction_bits[3:1]);
			o_timer_alternate_clock_in <= p2_in[1] & next_p2_schmitt[1] &
				port2_function_select_bits[1] & ~port2_direction_bits[1];
			o_timer_capture0_input_b <= p2_in[2] & next_p2_schmitt[2] &
				port2_function_select_bits[2] & ~port2_direction_bits[2];
			o_jtag_tck <= jtag_on & p1_in[4];
			o_jtag_tms <= jtag_on ? p1_in[5] : 1'b1;
			o_jtag_tdi_test_clock_input <= jtag_on & p1_in[6];
			o_jtag_pin7_in <= jtag_on & p1_in[7];
			o_jtag_enable <= jtag_on;
			o_jtag_bypass <= fuse_latched;
			if (i_read) begin
				case (i_addr)
				`REG_P1_DIR: o_rdata <= port1_direction_bits;
				`REG_P1_SEL: o_rdata <= port1_function_select_bits;
				`REG_P2_DIR: o_rdata <= port2_direction_bits;
				`REG_P2_SEL: o_rdata <= port2_function_select_bits;
				`REG_PIN_OFF: o_rdata <= comparator_pin_disable_bits;
				`REG_CA_SEL: o_rdata <= {3'h0, comparator_select};
				`REG_STATUS: o_rdata <= {5'h00, fuse_latched, jtag_on,
					test_sync};
				`REG_P1_IN: o_rdata <= p1_in;
				default: o_rdata <= 8'h00;
				endcase
			end else begin
				o_rdata <= 8'h00;
			end
		end
	end
endmodule // port_pin_function_mux

// ---- dv/port_pin_function_mux_props.sv ----
// port checks for the pin function multiplexer
`timescale 1ns/1ps
module port_pin_function_mux_props (
	input wire i_clk,
	input wire i_reset,
	input wire [2:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_write,
	input wire i_fuse_blown,
	input wire [7:0] o_port1_oe,
	input wire [7:0] o_port2_oe,
	input wire [7:0] o_port2_schmitt_en,
	input wire [7:0] o_port2_analog_sel,
	input wire o_jtag_enable,
	input wire o_jtag_bypass
);
reg [7:0] dir1;
reg [7:0] dir2;
reg [7:0] pin_off;
// ==========================================
// shadow of written directions and disables
always @(posedge i_clk) begin
	if (i_reset) begin
		dir1 <= 8'h00;
		dir2 <= 8'h00;
		pin_off <= 8'h00;
	end else if (i_write) begin
		if (i_addr == 3'h0) dir1 <= i_wdata;
		if (i_addr == 3'h2) dir2 <= i_wdata;
		if (i_addr == 3'h4) pin_off <= i_wdata;
	end
end
default clocking @(posedge i_clk); endclocking
default disable iff (i_reset);
// ==========================================
// properties
rst_quiet_a: assert property (disable iff (1'b0)
	i_reset |=> o_port1_oe == 8'h00 && o_port2_oe == 8'h00
	&& o_port2_schmitt_en == 8'hff) else $error("pins active after reset");
p1_drive_a: assert property (!$past(i_reset)
	|-> o_port1_oe[3:0] == $past(dir1[3:0])) else $error("port 1 enable");
p2_drive_a: assert property (!$past(i_reset)
	|-> o_port2_oe == ($past(dir2) & ~$past(pin_off)))
	else $error("port 2 enable");
off_cut_a: assert property (!$past(i_reset)
	|-> (o_port2_schmitt_en & $past(pin_off)) == 8'h00)
	else $error("disabled pin keeps input buffer");
ana_cut_a: assert property (
	(o_port2_analog_sel & o_port2_schmitt_en) == 8'h00)
	else $error("analog pin keeps input buffer");
test_pins_a: assert property (
	o_jtag_enable |-> o_port1_oe[5:4] == 2'h0) else $error("test pin driven");
bypass_keep_a: assert property (
	o_jtag_bypass |=> o_jtag_bypass) else $error("bypass dropped");
bypass_off_a: assert property (
	o_jtag_bypass |-> !o_jtag_enable) else $error("test port open in bypass");
fuse_bypass_a: assert property (
	i_fuse_blown [*8] |-> o_jtag_bypass) else $error("fuse ignored");
endmodule // port_pin_function_mux_props
bind port_pin_function_mux port_pin_function_mux_props u_props (.*);

// ---- dv/pin_board_model.sv ----
// board levels and pad resolution for both ports
`timescale 1ns/1ps
module pin_board_model (
	input wire [7:0] i_out1,
	input wire [7:0] i_oe1,
	input wire [7:0] i_out2,
	input wire [7:0] i_oe2,
	input wire [7:0] i_board1,
	input wire [7:0] i_board2,
	output wire [7:0] o_pad1,
	output wire [7:0] o_pad2
);
// ==========================================
// board drives only pins the device leaves free
assign o_pad1 = (i_oe1 & i_out1) | (~i_oe1 & i_board1);
assign o_pad2 = (i_oe2 & i_out2) | (~i_oe2 & i_board2);
endmodule // pin_board_model

// ---- dv/test_port_pin_function_mux.sv ----
// self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
module test_port_pin_function_mux;
reg i_clk = 1'b0, i_reset = 1'b1, i_write = 1'b0, i_read = 1'b0;
reg [2:0] i_addr = 3'h0;
reg [7:0] i_wdata = 8'h00, i_port1_gpio_out = 8'h00, i_port2_gpio_out = 8'h00;
reg i_test_mode = 1'b0, i_fuse_blown = 1'b0;
reg i_jtag_pin6_drive = 1'b0, i_jtag_pin7_drive = 1'b0, i_jtag_tdo = 1'b0;
reg [5:0] pv = 6'h00;
reg [7:0] b1 = 8'h00, b2 = 8'h00, d1, s1, d2, s2, off, e1, e2, m, q1, q2;
reg [4:0] ca;
reg [7:0] ex;
reg [31:0] seed = 32'h47010f5e;
integer bad_count = 0, num_checks = 0, k;
wire i_timer_channel0_output = pv[0], i_timer_channel1_output = pv[1];
wire i_timer_channel2_output = pv[2], i_sub_main_clock_output = pv[3];
wire i_aux_clock_output = pv[4], i_comparator_result_output = pv[5];
wire [7:0] p1v = {pv[2], pv[1], pv[0], pv[3], pv[2], pv[1], pv[0], 1'b0};
wire [7:0] p2v = {3'h0, pv[2], pv[1], pv[5], 1'b0, pv[4]};
wire [7:0] o_rdata, o_port1_out, o_port1_oe, o_port2_out, o_port2_oe;
wire [7:0] o_port2_schmitt_en, o_port2_analog_sel, o_port1_gpio_in;
wire [7:0] o_port2_gpio_in, i_port1_pad, i_port2_pad;
wire o_timer_external_clock_in, o_timer_alternate_clock_in;
wire o_timer_capture0_input_a, o_timer_capture0_input_b;
wire [3:0] tmr = {o_timer_external_clock_in, o_timer_capture0_input_a,
	o_timer_alternate_clock_in, o_timer_capture0_input_b};
wire o_jtag_tck, o_jtag_tms, o_jtag_tdi_test_clock_input, o_jtag_pin7_in;
wire o_jtag_enable, o_jtag_bypass;
port_pin_function_mux i_port_pin_function_mux (.*);
pin_board_model i_pin_board_model (.i_out1(o_port1_out), .i_oe1(o_port1_oe),
	.i_out2(o_port2_out), .i_oe2(o_port2_oe), .i_board1(b1), .i_board2(b2),
	.o_pad1(i_port1_pad), .o_pad2(i_port2_pad));
always #12.5 i_clk = ~i_clk;
// ==========================================
// reference model and bus tasks
function [31:0] xs(input [31:0] v);
	reg [31:0] t;
	begin
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	end
endfunction
function [7:0] cam(input [4:0] c);
	begin
		cam = 8'h00;
		if ({c[4], c[0]} != 2'h0) cam[12'h118 >> ({c[4], c[0]} * 3) & 3'h7] = 1'b1;
		if (c[3:1] != 3'h0) cam[24'hfaa220 >> (c[3:1] * 3) & 3'h7] = 1'b1;
	end
endfunction
task chk(input [7:0] a, input [7:0] x);
	begin
		num_checks = num_checks + 1;
		if (a !== x) begin
			bad_count = bad_count + 1;
			$display("Error at %0t: got %h expected %h", $time, a, x);
		end
	end
endtask
task wr(input [2:0] a, input [7:0] d);
	begin
		i_addr <= a;
		i_wdata <= d;
		i_write <= 1'b1;
		@(posedge i_clk);
		i_write <= 1'b0;
		#1;
	end
endtask
// read data stand only in the cycle after the strobe
task rd(input [2:0] a, input [7:0] x);
	begin
		i_addr <= a;
		i_read <= 1'b1;
		@(posedge i_clk);
		i_read <= 1'b0;
		#1;
		chk(o_rdata, x);
	end
endtask
task test_done;
	begin
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
endtask
// ==========================================
// sequence
initial begin
	repeat (8) @(posedge i_clk);
	i_reset <= 1'b0;
	@(posedge i_clk);
	#1;
	chk(o_port1_oe | o_port2_oe, 8'h00);
	for (k = 0; k < 6; k = k + 1)
		rd(k[2:0], 8'h00);
	for (k = 0; k < 64; k = k + 1) begin
		seed = xs(seed);
		{d1, s1, d2, s2} = seed;
		seed = xs(seed);
		off = seed[7:0] & seed[15:8];
		ca = k[4:0];
		i_port1_gpio_out <= seed[23:16];
		i_port2_gpio_out <= seed[31:24];
		seed = xs(seed);
		pv <= seed[5:0];
		{b1, b2} = seed[23:8];
		wr(3'h0, d1);
		wr(3'h1, s1);
		wr(3'h2, d2);
		wr(3'h3, s2);
		wr(3'h4, off);
		wr(3'h5, {3'h0, ca});
		rd(3'h3, s2);
		repeat (8) @(posedge i_clk);
		#1;
		e1 = (s1 & p1v) | (~s1 & i_port1_gpio_out);
		e2 = (s2 & p2v) | (~s2 & i_port2_gpio_out);
		m = d2 & ~off;
		chk(o_port1_oe, d1);
		chk(o_port1_out & d1, e1 & d1);
		chk(o_port2_out & d2, e2 & d2);
		chk(o_port2_oe, m);
		chk(o_port2_analog_sel, cam(ca));
		chk(o_port2_schmitt_en, ~(off | cam(ca)));
		q1 = (d1 & e1) | (~d1 & b1);
		q2 = ((m & e2) | (~m & b2)) & ~(off | cam(ca));
		chk(o_port1_gpio_in, q1);
		chk(o_port2_gpio_in, q2);
		ex = {4'h0, q1[0] & s1[0] & ~d1[0], |(q1[3:1] & s1[3:1] & ~d1[3:1]),
			q2[1] & s2[1] & ~d2[1], q2[2] & s2[2] & ~d2[2]};
		chk({4'h0, tmr}, ex);
		rd(3'h7, q1);
	end
	i_test_mode <= 1'b1;
	i_jtag_pin6_drive <= seed[24];
	i_jtag_pin7_drive <= 1'b1;
	i_jtag_tdo <= 1'b1;
	// pads settle only after the sync chain has seen the new enables
	repeat (12) @(posedge i_clk);
	#1;
	ex = {1'b1, seed[24], 6'h01};
	chk({o_port1_oe[7:4], 3'h0, o_jtag_enable}, ex);
	ex = {6'h01, b1[4], b1[5]};
	chk({5'h0, o_port1_out[7], o_jtag_tck, o_jtag_tms}, ex);
	ex = {6'h00, b1[6] & ~seed[24], 1'b1};
	chk({6'h0, o_jtag_tdi_test_clock_input, o_jtag_pin7_in}, ex);
	rd(3'h6, 8'h03);
	i_fuse_blown <= 1'b1;
	repeat (10) @(posedge i_clk);
	i_fuse_blown <= 1'b0;
	i_reset <= 1'b1;
	repeat (2) @(posedge i_clk);
	i_reset <= 1'b0;
	repeat (8) @(posedge i_clk);
	#1;
	chk({6'h0, o_jtag_bypass, o_jtag_enable}, 8'h02);
	rd(3'h6, 8'h05);
	test_done;
end
initial begin
	#200000;
	bad_count = bad_count + 1;
	test_done;
end
endmodule // test_port_pin_function_mux
